/* src/temp_sense_cfg.svh */
// Purpose: Constants for the temperature sense reporting block
// Assumes: 100 MHz sys_clk, 12-bit duty codes as 4096ths of full scale
// Notes: Definitions only
`ifndef TEMP_SENSE_CFG_SVH
`define TEMP_SENSE_CFG_SVH
`define ADDR_PRIMARY_STATUS 7'h01
`define ADDR_REMOTE_DUTY 7'h08
`define ADDR_DIE_DUTY 7'h09
`define ADDR_SENSE_CONFIG 7'h53
`define STAT_UPDATE_FAULT_BIT 3
`define CFG_BIAS_OFF_BIT 0
`define CFG_COMP_EN_BIT 1
`define CFG_COMP_SEL_BIT 2
`define CFG_FILT_BYPASS_BIT 3
`define CFG_RESET 8'h00
`define SAMPLE_PERIOD_NS 100000
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_NS / 10)
`define PWM_PERIOD_NS 1000000
`define PWM_CYCLES (`PWM_PERIOD_NS / 10)
`define COMP_FILT_NS 1640000
`define COMP_FILT_CYCLES (`COMP_FILT_NS / 10)
`define STARTUP_VALID_NS 3150000
`define STARTUP_VALID_CYCLES (`STARTUP_VALID_NS / 10)
`define DUTY_MAX 12'hfae
`define DUTY_MIN 12'h066
`define DUTY_FIXED 12'h066
`define DUTY_SHIFT 12
`define UPDATE_MISS_LIMIT 2'h2
`define STARTUP_SETTLE_DIV 4
`define WORD_BITS 24
`define CRC_POLY 8'h07
`endif

/* src/temp_sense_pkg.sv */
// Purpose: Types for the temperature sense reporting block
// Assumes: Constants come from temp_sense_cfg.svh
// Notes: Types only
package temp_sense_pkg;
    typedef logic [11:0] duty_t;
    typedef enum logic [2:0] {
        SPI_IDLE = 3'b001,
        SPI_SHIFT = 3'b010,
        SPI_DONE = 3'b100
    } spi_state_e;
endpackage

/* src/temperature_sense_reporting.sv */
// Purpose: Filter, report and watch the remote and die temperature sense codes
// Assumes: Duty codes arrive already digitised each sample; SPI pins are sync to sys_clk
// Notes: Duty reads give the low byte of each 12-bit code; PWM scales to the period
`timescale 1ns/1ps
`default_nettype none
`include "temp_sense_cfg.svh"
module temperature_sense_reporting
    import temp_sense_pkg::*;
#(
    parameter int SAMPLE_CYC = `SAMPLE_CYCLES,
    parameter int PWM_CYC = `PWM_CYCLES,
    parameter int FILT_CYC = `COMP_FILT_CYCLES,
    parameter int STARTUP_CYC = `STARTUP_VALID_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] remote_sample,
    input wire logic [11:0] die_sample,
    input wire logic remote_in_range,
    input wire logic sample_link_up,
    input wire logic below_low_thresh,
    input wire logic above_high_thresh,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic temp_pwm_out,
    output logic bias_disable,
    output logic driver_fault_flag_low,
    output logic temp_out_valid
);
    ////////////////////////////////////////////////////////////////////////
    // Sample timing, filter and transfer
    logic [19:0] samp_cnt_reg, samp_cnt_next;
    duty_t remote_filt_reg, remote_filt_next, die_filt_reg, die_filt_next;
    duty_t remote_duty_reg, remote_duty_next, die_duty_reg, die_duty_next;
    logic update_reg, update_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] status_reg, status_next;
    duty_t remote_clamped;

    // Clamp before filtering so an out-of-range pin cannot drag the average
    always_comb begin
        if (!remote_in_range) begin
            remote_clamped = `DUTY_FIXED;
        end else if (remote_sample > `DUTY_MAX) begin
            remote_clamped = `DUTY_MAX;
        end else if (remote_sample < `DUTY_MIN) begin
            remote_clamped = `DUTY_MIN;
        end else begin
            remote_clamped = remote_sample;
        end
    end

    // Sample tick every 100 us; filtered result lands in the duty registers
    always_comb begin
        samp_cnt_next = samp_cnt_reg + 20'h00001;
        remote_filt_next = remote_filt_reg;
        die_filt_next = die_filt_reg;
        remote_duty_next = remote_duty_reg;
        die_duty_next = die_duty_reg;
        update_next = 1'b0;
        if (samp_cnt_reg == 20'(SAMPLE_CYC - 1)) begin
            samp_cnt_next = 20'h00000;
            // Previous result moves at the edge starting the next cycle
            remote_filt_next = 12'((13'(remote_filt_reg) + 13'(remote_clamped)) >> 1);
            die_filt_next = 12'((13'(die_filt_reg) + 13'(die_sample)) >> 1);
            if (sample_link_up) begin
                remote_duty_next = remote_filt_reg;
                die_duty_next = die_filt_reg;
                update_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            samp_cnt_reg <= 20'h00000;
            remote_filt_reg <= 12'h000;
            die_filt_reg <= 12'h000;
            remote_duty_reg <= 12'h000;
            die_duty_reg <= 12'h000;
            update_reg <= 1'b0;
        end else begin
            samp_cnt_reg <= samp_cnt_next;
            remote_filt_reg <= remote_filt_next;
            die_filt_reg <= die_filt_next;
            remote_duty_reg <= remote_duty_next;
            die_duty_reg <= die_duty_next;
            update_reg <= update_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM output, startup validity and update watchdog
    logic [16:0] pwm_cnt_reg, pwm_cnt_next;
    logic pwm_reg, pwm_next;
    logic [1:0] miss_reg, miss_next;
    logic [21:0] start_cnt_reg, start_cnt_next;
    logic valid_reg, valid_next;
    logic fault_set;
    logic [16:0] pwm_high_reg, pwm_high_next;
    logic [31:0] pwm_prod;

    // Duty code as a fraction of full scale, applied to whatever period is set
    assign pwm_prod = 32'(remote_duty_reg) * 32'(PWM_CYC);

    always_comb begin
        pwm_cnt_next = (pwm_cnt_reg == 17'(PWM_CYC - 1)) ? 17'h00000 : pwm_cnt_reg + 17'h00001;
        miss_next = miss_reg;
        fault_set = 1'b0;
        if (update_reg) begin
            miss_next = 2'h0;
        end else if (pwm_cnt_reg == 17'h00000 && miss_reg != `UPDATE_MISS_LIMIT) begin
            miss_next = miss_reg + 2'h1;
        end
        if (miss_reg == `UPDATE_MISS_LIMIT) begin
            fault_set = 1'b1;
        end
        // High time is taken only at period start, so a duty step or a resume never
        // cuts a period short; stale data zeroes it at once
        pwm_high_next = pwm_high_reg;
        if (miss_reg == `UPDATE_MISS_LIMIT) begin
            pwm_high_next = 17'h00000;
        end else if (pwm_cnt_reg == 17'(PWM_CYC - 1)) begin
            pwm_high_next = valid_reg ? 17'(pwm_prod >> `DUTY_SHIFT) : 17'h00000;
        end
        // Output idles low while data is stale, resumes at a period start
        pwm_next = (miss_reg != `UPDATE_MISS_LIMIT) && (pwm_cnt_reg < pwm_high_reg);
        start_cnt_next = start_cnt_reg;
        valid_next = valid_reg;
        if (!valid_reg && update_reg) begin
            start_cnt_next = start_cnt_reg + 22'h000001;
            // Wait a few samples so the filter has settled
            if (start_cnt_reg == 22'(STARTUP_CYC / SAMPLE_CYC / `STARTUP_SETTLE_DIV)) begin
                valid_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pwm_cnt_reg <= 17'h00000;
            pwm_reg <= 1'b0;
            pwm_high_reg <= 17'h00000;
            miss_reg <= 2'h0;
            start_cnt_reg <= 22'h000000;
            valid_reg <= 1'b0;
        end else begin
            pwm_cnt_reg <= pwm_cnt_next;
            pwm_reg <= pwm_next;
            pwm_high_reg <= pwm_high_next;
            miss_reg <= miss_next;
            start_cnt_reg <= start_cnt_next;
            valid_reg <= valid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparator with optional filter
    logic [17:0] filt_cnt_reg, filt_cnt_next;
    logic trip_reg, trip_next;
    logic raw_trip;

    always_comb begin
        // Only one threshold is ever active, chosen by the select bit
        raw_trip = cfg_reg[`CFG_COMP_EN_BIT] &&
            (cfg_reg[`CFG_COMP_SEL_BIT] ? above_high_thresh : below_low_thresh);
        filt_cnt_next = 18'h00000;
        trip_next = trip_reg;
        if (cfg_reg[`CFG_FILT_BYPASS_BIT]) begin
            trip_next = raw_trip;
        end else if (raw_trip != trip_reg) begin
            filt_cnt_next = filt_cnt_reg + 18'h00001;
            if (filt_cnt_reg == 18'(FILT_CYC - 1)) begin
                trip_next = raw_trip;
                filt_cnt_next = 18'h00000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            filt_cnt_reg <= 18'h00000;
            trip_reg <= 1'b0;
        end else begin
            filt_cnt_reg <= filt_cnt_next;
            trip_reg <= trip_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SPI slave, 24-bit words, commands act on chip select release
    spi_state_e spi_state_reg, spi_state_next;
    logic [23:0] rx_reg, rx_next, tx_reg, tx_next;
    logic [5:0] bit_cnt_reg, bit_cnt_next;
    logic sclk_d_reg, miso_reg, miso_next;
    logic drv_fault_reg;
    logic [7:0] rd_data, crc_calc;
    logic [15:0] rd_word;

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Read mux; duty registers expose the low byte only in an 8-bit field
    always_comb begin
        unique case (rx_reg[22:16])
            `ADDR_PRIMARY_STATUS: rd_data = status_reg;
            `ADDR_REMOTE_DUTY: rd_data = remote_duty_reg[7:0];
            `ADDR_DIE_DUTY: rd_data = die_duty_reg[7:0];
            `ADDR_SENSE_CONFIG: rd_data = cfg_reg;
            default: rd_data = 8'h00;
        endcase
        rd_word = {rx_reg[23], rx_reg[22:16], rd_data};
        crc_calc = crc8(rx_reg[23:8]);
    end

    always_comb begin
        spi_state_next = spi_state_reg;
        rx_next = rx_reg;
        tx_next = tx_reg;
        bit_cnt_next = bit_cnt_reg;
        miso_next = miso_reg;
        cfg_next = cfg_reg;
        status_next = status_reg;
        unique case (spi_state_reg)
            SPI_IDLE: begin
                if (!spi_cs_n) begin
                    spi_state_next = SPI_SHIFT;
                    bit_cnt_next = 6'h00;
                    miso_next = tx_reg[23];
                end
            end
            SPI_SHIFT: begin
                if (spi_cs_n) begin
                    spi_state_next = SPI_DONE;
                end else if (spi_sclk && !sclk_d_reg) begin
                    rx_next = {rx_reg[22:0], spi_mosi};
                    bit_cnt_next = bit_cnt_reg + 6'h01;
                end else if (!spi_sclk && sclk_d_reg) begin
                    tx_next = {tx_reg[22:0], 1'b0};
                    miso_next = tx_reg[22];
                end
            end
            SPI_DONE: begin
                spi_state_next = SPI_IDLE;
                // Bad length or CRC aborts; the reply then reads as zero
                if (bit_cnt_reg == 6'(`WORD_BITS) && crc_calc == rx_reg[7:0]) begin
                    tx_next = {rd_word, crc8(rd_word)};
                    if (!rx_reg[23] && rx_reg[22:16] == `ADDR_SENSE_CONFIG) begin
                        cfg_next = rx_reg[15:8];
                    end
                    if (!rx_reg[23] && rx_reg[22:16] == `ADDR_PRIMARY_STATUS &&
                        rx_reg[8 + `STAT_UPDATE_FAULT_BIT]) begin
                        status_next[`STAT_UPDATE_FAULT_BIT] = 1'b0;
                    end
                end else begin
                    tx_next = 24'h000000;
                end
            end
            default: spi_state_next = SPI_IDLE;
        endcase
        // Hardware set beats a same-cycle clear
        if (fault_set) begin
            status_next[`STAT_UPDATE_FAULT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            spi_state_reg <= SPI_IDLE;
            rx_reg <= 24'h000000;
            tx_reg <= 24'h000000;
            bit_cnt_reg <= 6'h00;
            sclk_d_reg <= 1'b0;
            miso_reg <= 1'b0;
            cfg_reg <= `CFG_RESET;
            status_reg <= 8'h00;
            drv_fault_reg <= 1'b1;
        end else begin
            spi_state_reg <= spi_state_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            bit_cnt_reg <= bit_cnt_next;
            sclk_d_reg <= spi_sclk;
            miso_reg <= miso_next;
            cfg_reg <= cfg_next;
            status_reg <= status_next;
            drv_fault_reg <= !trip_reg;
        end
    end

    // All outputs straight from flip-flops
    assign spi_miso = miso_reg;
    assign temp_pwm_out = pwm_reg;
    assign bias_disable = cfg_reg[`CFG_BIAS_OFF_BIT];
    assign driver_fault_flag_low = drv_fault_reg;
    assign temp_out_valid = valid_reg;
endmodule
`default_nettype wire

/* sim/temp_sense_checker_asserts.sv */
// Purpose: Port checker for temperature_sense_reporting
// Assumes: Counts shortened by the bench through parameters
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module temp_sense_checker #(
    parameter int PWM_CYC = 200,
    parameter int STARTUP_CYC = 200
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_miso,
    input wire logic temp_pwm_out,
    input wire logic bias_disable,
    input wire logic driver_fault_flag_low,
    input wire logic temp_out_valid,
    input wire logic below_low_thresh,
    input wire logic above_high_thresh
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic [31:0] wait_reg, wait_next, gap_reg, gap_next, hi_reg, hi_next;
    logic pwm_d_reg, pwm_d_next, seen_reg, seen_next;
    //////////////////////////////////////////////////
    // Counters; the gap is only judged once a first rise was seen
    always_comb begin
        wait_next = wait_reg + {31'h0, !temp_out_valid};
        gap_next = (temp_pwm_out && !pwm_d_reg) ? 32'h0 : gap_reg + 32'h1;
        hi_next = temp_pwm_out ? hi_reg + 32'h1 : 32'h0;
        pwm_d_next = temp_pwm_out;
        seen_next = seen_reg || (temp_pwm_out && !pwm_d_reg);
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {wait_reg, gap_reg, hi_reg, pwm_d_reg, seen_reg} <= '0;
        end else begin
            {wait_reg, gap_reg, hi_reg, pwm_d_reg, seen_reg} <=
                {wait_next, gap_next, hi_next, pwm_d_next, seen_next};
        end
    end
    //////////////////////////////////////////////////
    AST_BIAS_RESET: assert property ($fell(rst) |-> !bias_disable)
        else $error("bias disable set after reset");
    AST_COMP_RESET: assert property ($fell(rst) |-> driver_fault_flag_low)
        else $error("fault flag low after reset");
    AST_VALID_RESET: assert property ($fell(rst) |-> !temp_out_valid)
        else $error("valid set straight after reset");
    AST_VALID_TIME: assert property (wait_reg <= STARTUP_CYC)
        else $error("output not valid in time");
    AST_BIAS_CHANGE: assert property ($changed(bias_disable) |-> spi_cs_n && $past(spi_cs_n))
        else $error("bias changed inside a frame");
    AST_PWM_GAP: assert property (temp_pwm_out && !pwm_d_reg && seen_reg |->
        gap_reg >= PWM_CYC - 1) else $error("pwm period too short");
    AST_PWM_HIGH: assert property (hi_reg <= PWM_CYC * 99 / 100)
        else $error("pwm high beyond clamp");
    AST_FAULT_CAUSE: assert property ($fell(driver_fault_flag_low) |->
        $past(below_low_thresh) || $past(above_high_thresh)) else $error("fault without trip");
    AST_MISO_EDGE: assert property ($changed(spi_miso) |-> !spi_sclk)
        else $error("miso changed with sclk high");
    cover property ($fell(driver_fault_flag_low));
    cover property ($rose(bias_disable));
    cover property ($rose(temp_out_valid));
endmodule
bind temperature_sense_reporting temp_sense_checker #(.PWM_CYC(PWM_CYC),
    .STARTUP_CYC(STARTUP_CYC)) temp_sense_checker_i (.sys_clk, .rst, .spi_cs_n, .spi_sclk,
    .spi_miso, .temp_pwm_out, .bias_disable, .driver_fault_flag_low, .temp_out_valid,
    .below_low_thresh, .above_high_thresh);
`default_nettype wire

/* sim/spi_host_model.sv */
// Purpose: SPI host framing 24-bit words toward the block
// Assumes: Three sys_clk per SCLK phase, mode 0, MSB first
// Notes: MOSI shows the inverse of the last bit outside a frame
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic sys_clk,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    //////////////////////////////////////////////////
    // Check byte over command, address and data
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        return c;
    endfunction
    // One whole word per frame; reply bits taken just before each falling SCLK
    task automatic xfer(input logic [23:0] w, output logic [23:0] r);
        r = 24'h0;
        @(posedge sys_clk);
        spi_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi <= w[i];
            repeat (3) @(posedge sys_clk);
            spi_sclk <= 1'b1;
            repeat (3) @(posedge sys_clk);
            r = {r[22:0], spi_miso};
            spi_sclk <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~w[0];
        repeat (4) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* sim/temperature_sense_reporting_tb.sv */
// Purpose: Self-checking bench for temperature_sense_reporting
// Assumes: Short counts set through parameters; host model on the SPI pins
// Notes: Duty reads return the low byte of the 12-bit code
`timescale 1ns/1ps
`default_nettype none
module temperature_sense_reporting_tb;
    localparam int SMP = 20;
    localparam int PWM = 200;
    localparam int FLT = 10;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] remote_sample = 12'h805;
    logic [11:0] die_sample = 12'h3c1;
    logic remote_in_range = 1'b1;
    logic sample_link_up = 1'b1;
    logic below_low_thresh = 1'b0;
    logic above_high_thresh = 1'b0;
    logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, temp_pwm_out;
    logic bias_disable, driver_fault_flag_low, temp_out_valid;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    int k;
    logic [7:0] d;
    logic [23:0] r;
    always #5 sys_clk = ~sys_clk;
    temperature_sense_reporting #(.SAMPLE_CYC(SMP), .PWM_CYC(PWM), .FILT_CYC(FLT),
        .STARTUP_CYC(200)) temperature_sense_reporting_i (.sys_clk, .rst, .remote_sample,
        .die_sample, .remote_in_range, .sample_link_up, .below_low_thresh, .above_high_thresh,
        .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso, .temp_pwm_out, .bias_disable,
        .driver_fault_flag_low, .temp_out_valid);
    spi_host_model spi_host_model_i (.sys_clk, .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso);
    //////////////////////////////////////////////////
    // Compares; an unknown never passes
    task automatic check_eq(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Filter rounding may leave the code one below the input
    task automatic check_in(input string nm, input logic [7:0] lo, input logic [7:0] g);
        num_checks++;
        if ((g >= lo && g <= lo + 8'h01) !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, lo, g);
        end
    endtask
    function automatic logic [23:0] cmd(input logic rw, input logic [6:0] a, input logic [7:0] v);
        return {rw, a, v, spi_host_model_i.crc8({rw, a, v})};
    endfunction
    task automatic wr(input logic [6:0] a, input logic [7:0] v, input logic [7:0] flip);
        spi_host_model_i.xfer(cmd(1'b0, a, v) ^ {16'h0, flip}, r);
    endtask
    // The reply comes in the following frame
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        spi_host_model_i.xfer(cmd(1'b1, a, 8'h00), r);
        spi_host_model_i.xfer(cmd(1'b1, a, 8'h00), r);
        v = r[15:8];
    endtask
    task automatic trip(input logic lo, input logic hi, input int n, input logic e);
        below_low_thresh <= lo;
        above_high_thresh <= hi;
        repeat (n) @(posedge sys_clk);
        check_eq("fault flag", {23'h0, e}, {23'h0, driver_fault_flag_low});
        below_low_thresh <= 1'b0;
        above_high_thresh <= 1'b0;
        repeat (FLT + 4) @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            print_verdict();
        end
    end
    //////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        for (k = 0; k < 200 && temp_out_valid !== 1'b1; k++) @(posedge sys_clk);
        check_eq("valid", 24'h1, {23'h0, temp_out_valid});
        rd(7'h53, d);
        check_eq("cfg reset", 24'h0, {16'h0, d});
        repeat (20 * SMP) @(posedge sys_clk);
        rd(7'h08, d);
        check_in("remote", 8'h04, d);
        rd(7'h09, d);
        check_in("die", 8'hc0, d);
        wr(7'h08, 8'h00, 8'h00);
        rd(7'h08, d);
        check_in("remote ro", 8'h04, d);
        for (k = 0; k < 2 * PWM && temp_pwm_out !== 1'b0; k++) @(posedge sys_clk);
        for (k = 0; k < 2 * PWM && temp_pwm_out !== 1'b1; k++) @(posedge sys_clk);
        for (k = 0; k < 2 * PWM && temp_pwm_out === 1'b1; k++) @(posedge sys_clk);
        check_eq("pwm high", 24'h1, {23'h0, k > 94 && k < 107});
        for (int i = 0; i < 3; i++) begin
            remote_sample <= (i == 1) ? 12'h000 : 12'hfff;
            remote_in_range <= (i != 2);
            repeat (20 * SMP) @(posedge sys_clk);
            rd(7'h08, d);
            // Half-weight averaging truncates, so it settles one code under the top clamp
            check_eq("clamp", (i == 0) ? 24'had : 24'h66, {16'h0, d});
        end
        remote_in_range <= 1'b1;
        wr(7'h53, 8'h01, 8'h00);
        check_eq("bias off", 24'h1, {23'h0, bias_disable});
        wr(7'h53, 8'h00, 8'h01);
        check_eq("bad crc", 24'h1, {23'h0, bias_disable});
        spi_host_model_i.xfer(cmd(1'b1, 7'h53, 8'h00), r);
        check_eq("bad reply", 24'h0, r);
        trip(1'b1, 1'b1, 20, 1'b1);
        for (int s = 0; s < 2; s++) begin
            wr(7'h53, s[0] ? 8'h0e : 8'h0a, 8'h00);
            trip(s[0], !s[0], 5, 1'b1);
            trip(!s[0], s[0], 5, 1'b0);
            wr(7'h53, s[0] ? 8'h06 : 8'h02, 8'h00);
            trip(!s[0], s[0], FLT - 3, 1'b1);
            trip(!s[0], s[0], FLT + 4, 1'b0);
        end
        wr(7'h53, 8'h00, 8'h00);
        sample_link_up <= 1'b0;
        repeat (3 * PWM + 20) @(posedge sys_clk);
        rd(7'h01, d);
        check_eq("update fault", 24'h8, {16'h0, d & 8'h08});
        sample_link_up <= 1'b1;
        for (k = 0; k < 3 * PWM && temp_pwm_out !== 1'b1; k++) @(posedge sys_clk);
        check_eq("pwm resumed", 24'h1, {23'h0, temp_pwm_out});
        wr(7'h01, 8'h00, 8'h00);
        rd(7'h01, d);
        check_eq("fault held", 24'h8, {16'h0, d & 8'h08});
        wr(7'h01, 8'h08, 8'h00);
        rd(7'h01, d);
        check_eq("fault cleared", 24'h0, {16'h0, d & 8'h08});
        print_verdict();
    end
endmodule
`default_nettype wire
